// >>> src/arb_slice_pkg.sv
// Constants for one master's slice of the distributed bus arbiter.
// Assumes a single bus clock domain; the master request arrives already synchronised.
package arb_slice_pkg;
  localparam int unsigned NUM_LINES = 8;
  localparam int unsigned INFO_WIDTH = 16;
  localparam int unsigned CONTROL_LINES = 21;
  localparam int unsigned MAX_DOUBLE_WORDS = 128;
  localparam logic [7:0] LINES_RESET = 8'h00;
  localparam logic [7:0] BURST_COUNT_RESET = 8'h00;
  localparam logic [3:0] TARGET_RESET = 4'h0;
  localparam logic [1:0] FUNC_INTERRUPT = 2'h1;
  localparam logic [1:0] FUNC_RESET = 2'h2;
  localparam logic [1:0] FUNC_BOOT = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_OWN = 3'b100
  } arb_state_e;
endpackage : arb_slice_pkg

// >>> src/distributed_bus_arbiter_lock.sv
// One master's slice of a fixed-priority distributed bus arbiter with bus lock,
// plus the decoder for inter-processor interrupt, reset and boot writes.
// Assumes ref_clk is the bus clock and master-side inputs are already synchronous.
//
// How it works
// - Access request is registered on the sync strobe onto our request line.
// - Eight request lines, one per master; position gives priority.
// - Only request lines of higher-priority masters are looked at.
// - Own the bus when our request is up and no higher line is.
// - Lock-intent bit makes us drive the hold signal at our next grant.
// - Writers drop their request while another master holds the bus.
// - Read-only masters keep requesting even while the bus is held.
// - That write is decoded into reset, boot or interrupt to the target.
// - Bus transfers run on the bus clock; master inputs arrive synchronised.
// - Sixteen shared information lines and twenty-one control lines exist.
// - At most 128 double-word transfers in one tenure; the slice only raises burst_limit_reached, it does not end the tenure.
module distributed_bus_arbiter_lock #(
  parameter int unsigned MY_INDEX = 0,
  parameter bit READ_ONLY = 1'b0,
  parameter int unsigned NUM_PROCS = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic access_request,
  input wire logic lock_intent,
  input wire logic transfer_done,
  input wire logic double_word_strobe,
  input wire logic arbitration_sync_strobe,
  input wire logic [arb_slice_pkg::NUM_LINES-1:0] master_request_line_in,
  input wire logic exclusive_hold_in,
  input wire logic global_write,
  input wire logic [3:0] global_target,
  input wire logic [1:0] global_function,
  output logic master_request_line_n,
  output logic bus_granted,
  output logic exclusive_hold_signal,
  output logic burst_limit_reached,
  output logic [NUM_PROCS-1:0] proc_interrupt,
  output logic [NUM_PROCS-1:0] proc_reset,
  output logic [NUM_PROCS-1:0] proc_boot
);
  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: parameter values the logic cannot serve
  if (arb_slice_pkg::NUM_LINES != 8) begin : g_bad_lines
    $error("Backplane must carry eight request lines");
  end
  if (MY_INDEX >= arb_slice_pkg::NUM_LINES) begin : g_bad_index
    $error("MY_INDEX out of range");
  end
  if (NUM_PROCS > 16 || NUM_PROCS < 1) begin : g_bad_procs
    $error("NUM_PROCS must be 1..16");
  end
  if (arb_slice_pkg::INFO_WIDTH != 16 || arb_slice_pkg::CONTROL_LINES != 21) begin : g_bad_bus
    $error("Bus needs sixteen information and twenty-one control lines");
  end
  if (arb_slice_pkg::MAX_DOUBLE_WORDS > 255) begin : g_bad_burst
    $error("Burst counter too narrow for the tenure limit");
  end

  function automatic logic higher_busy(input logic [arb_slice_pkg::NUM_LINES-1:0] lines);
    logic any;
    any = 1'b0;
    for (int i = 0; i < arb_slice_pkg::NUM_LINES; i++) begin
      if (i < MY_INDEX) begin
        any = any | lines[i];
      end
    end
    return any;
  endfunction : higher_busy

  ////////////////////////////////////////////////////////////////////////////////
  // Request line
  arb_slice_pkg::arb_state_e state_reg, state_next;
  logic req_reg, req_next;
  logic hold_reg, hold_next;
  logic [7:0] burst_reg, burst_next;
  logic burst_flag_reg, burst_flag_next;
  logic blocked;
  logic tenure_end;
  logic grant_now;

  // Another master holds the bus; our own hold never blocks us
  assign blocked = exclusive_hold_in & ~hold_reg & ~READ_ONLY;
  // Tenure ends on the done pulse or when our own request has fallen
  assign tenure_end = (state_reg == arb_slice_pkg::ST_OWN) & (transfer_done | ~req_reg);
  // Win: waiting, on a sync boundary, with every higher line quiet
  assign grant_now = (state_reg == arb_slice_pkg::ST_WAIT) & req_reg & arbitration_sync_strobe
    & ~higher_busy(master_request_line_in);

  always_comb begin
    req_next = req_reg;
    if (arbitration_sync_strobe) begin
      req_next = access_request & ~blocked;
    end
    // Hold by another master (writers only, not READ_ONLY) or the end of our tenure always wins over a new request
    if (blocked || tenure_end) begin
      req_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ownership and hold
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    case (state_reg)
      arb_slice_pkg::ST_IDLE: begin
        if (req_reg) begin
          state_next = arb_slice_pkg::ST_WAIT;
        end
      end
      arb_slice_pkg::ST_WAIT: begin
        if (!req_reg) begin
          state_next = arb_slice_pkg::ST_IDLE;
        end else if (grant_now) begin
          state_next = arb_slice_pkg::ST_OWN;
          hold_next = lock_intent;
        end
      end
      arb_slice_pkg::ST_OWN: begin
        if (tenure_end) begin
          state_next = arb_slice_pkg::ST_IDLE;
          hold_next = 1'b0;
        end
      end
      default: begin
        state_next = arb_slice_pkg::ST_IDLE;
        hold_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= arb_slice_pkg::ST_IDLE;
      hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst count within one tenure; saturates at the limit
  always_comb begin
    burst_next = burst_reg;
    if (grant_now) begin
      burst_next = arb_slice_pkg::BURST_COUNT_RESET;
    end else if (bus_granted && double_word_strobe
        && burst_reg != 8'(arb_slice_pkg::MAX_DOUBLE_WORDS)) begin
      burst_next = burst_reg + 8'h01;
    end
    // Flag is registered so the output comes straight from a flip-flop
    burst_flag_next = (burst_next == 8'(arb_slice_pkg::MAX_DOUBLE_WORDS));
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      burst_reg <= arb_slice_pkg::BURST_COUNT_RESET;
      burst_flag_reg <= 1'b0;
    end else begin
      burst_reg <= burst_next;
      burst_flag_reg <= burst_flag_next;
    end
  end

  assign master_request_line_n = req_reg;
  assign bus_granted = (state_reg == arb_slice_pkg::ST_OWN);
  assign exclusive_hold_signal = hold_reg;
  assign burst_limit_reached = burst_flag_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Global location decode: one-cycle pulse to the addressed processor
  // Function code to one-hot action {boot, reset, interrupt}; code zero is no action
  function automatic logic [2:0] decode_action(input logic [1:0] code);
    logic [2:0] act;
    act = 3'h0;
    if (code == arb_slice_pkg::FUNC_INTERRUPT) begin
      act = 3'h1;
    end else if (code == arb_slice_pkg::FUNC_RESET) begin
      act = 3'h2;
    end else if (code == arb_slice_pkg::FUNC_BOOT) begin
      act = 3'h4;
    end
    return act;
  endfunction : decode_action

  function automatic logic target_hit(input logic [3:0] target, input int unsigned proc);
    return 32'(target) == proc;
  endfunction : target_hit

  // Targets at or above NUM_PROCS match no slot and are dropped
  for (genvar p = 0; p < NUM_PROCS; p++) begin : g_proc
    logic [2:0] act_reg, act_next;

    always_comb begin
      act_next = 3'h0;
      if (global_write && target_hit(global_target, p)) begin
        act_next = decode_action(global_function);
      end
    end

    // Each pulse stands one cycle, registered so the target sees a clean edge
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        act_reg <= 3'h0;
      end else begin
        act_reg <= act_next;
      end
    end

    assign proc_interrupt[p] = act_reg[0];
    assign proc_reset[p] = act_reg[1];
    assign proc_boot[p] = act_reg[2];
  end : g_proc
endmodule : distributed_bus_arbiter_lock

// >>> bench/arb_slice_chk.sv
// Assertions for one arbiter slice, bound to every instance of it.
// Assumes strobe, backplane lines and hold input come from the bus peer model.
module arb_slice_chk #(parameter int unsigned MY_INDEX = 0, parameter bit READ_ONLY = 1'b0,
  parameter int unsigned NUM_PROCS = 16) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic access_request,
  input wire logic lock_intent,
  input wire logic transfer_done,
  input wire logic arbitration_sync_strobe,
  input wire logic exclusive_hold_in,
  input wire logic global_write,
  input wire logic [7:0] master_request_line_in,
  input wire logic [3:0] global_target,
  input wire logic [1:0] global_function,
  input wire logic master_request_line_n,
  input wire logic bus_granted,
  input wire logic exclusive_hold_signal,
  input wire logic [NUM_PROCS-1:0] proc_interrupt,
  input wire logic [NUM_PROCS-1:0] proc_reset,
  input wire logic [NUM_PROCS-1:0] proc_boot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hi;
  logic win;
  // Any line of higher priority than ours is up
  assign hi = |(master_request_line_in & ((8'h01 << MY_INDEX) - 8'h01));
  assign win = arbitration_sync_strobe && master_request_line_n && !hi;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_req_on_sync: assert property (arbitration_sync_strobe && access_request
    && !exclusive_hold_in |=> master_request_line_n) else $error("request not raised");
  a_lock_blocks_req: assert property (exclusive_hold_in && !exclusive_hold_signal
    && !READ_ONLY |=> !master_request_line_n) else $error("request kept under hold");
  a_grant_clear: assert property ($rose(bus_granted) |-> $past(win))
    else $error("grant without a clear win");
  a_grant_on_win: assert property (win && $past(master_request_line_n) && !transfer_done
    && !exclusive_hold_in |=> bus_granted) else $error("win not granted");
  a_done_release: assert property (bus_granted && transfer_done |=> !bus_granted
    && !master_request_line_n && !exclusive_hold_signal) else $error("tenure not ended");
  a_lock_at_grant: assert property ($rose(bus_granted) |-> exclusive_hold_signal == lock_intent)
    else $error("hold differs from lock intent at grant");
  a_hold_owner: assert property (exclusive_hold_signal |-> bus_granted)
    else $error("hold without grant");
  a_irq_decode: assert property (global_write && global_function == 2'h1
    |=> proc_interrupt == (NUM_PROCS'(1) << $past(global_target))) else $error("bad irq");
  a_no_stray: assert property (!global_write |=> !(|{proc_interrupt, proc_reset, proc_boot}))
    else $error("stray processor pulse");
  c_grant: cover property ($rose(bus_granted));
  c_locked: cover property ($rose(exclusive_hold_signal));
  c_refused: cover property (exclusive_hold_in && access_request && !master_request_line_n);
endmodule : arb_slice_chk
bind distributed_bus_arbiter_lock arb_slice_chk #(.MY_INDEX(MY_INDEX), .READ_ONLY(READ_ONLY),
  .NUM_PROCS(NUM_PROCS)) chk (.*);

// >>> bench/bus_peer_model.sv
// Other masters on the backplane and the sync strobe source.
// Assumes one bus clock shared with the slice under test.
module bus_peer_model #(parameter int unsigned MY_INDEX = 0) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic other_hold,
  input wire logic master_request_line_n,
  input wire logic exclusive_hold_signal,
  input wire logic [7:0] other_lines,
  output logic arbitration_sync_strobe,
  output logic exclusive_hold_in,
  output logic [7:0] master_request_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_reg;
  always_ff @(posedge ref_clk) phase_reg <= srst ? 2'h0 : phase_reg + 2'h1;
  assign arbitration_sync_strobe = phase_reg == 2'h3;
  assign master_request_line_in = (other_lines & ~(8'h01 << MY_INDEX))
    | (8'(master_request_line_n) << MY_INDEX);
  assign exclusive_hold_in = other_hold | exclusive_hold_signal;
endmodule : bus_peer_model

// >>> bench/distributed_bus_arbiter_lock_tb_top.sv
// Bench for the slice at index 2 beside its backplane peer model.
// Assumes the checker is bound in by its own file.
module distributed_bus_arbiter_lock_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, srst = 1, access_request = 0, lock_intent = 0, transfer_done = 0;
  logic double_word_strobe = 0, global_write = 0, other_hold = 0, arbitration_sync_strobe;
  logic exclusive_hold_in, master_request_line_n, bus_granted, exclusive_hold_signal;
  logic burst_limit_reached;
  logic [7:0] other_lines = 0, master_request_line_in;
  logic [3:0] global_target = 0;
  logic [1:0] global_function = 0;
  logic [15:0] proc_interrupt, proc_reset, proc_boot;
  int err_count = 0, comparisons = 0, cycles = 0;
  logic [31:0] seed = 32'hf8c1_11ea;
  distributed_bus_arbiter_lock #(.MY_INDEX(2)) uut (.*);
  bus_peer_model #(.MY_INDEX(2)) peer (.*);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [47:0] exp_ipc(input logic [3:0] t, input logic [1:0] f);
    logic [15:0] e;
    e = 16'h0001 << t;
    return {f == arb_slice_pkg::FUNC_INTERRUPT ? e : 16'h0000,
      f == arb_slice_pkg::FUNC_RESET ? e : 16'h0000, f == arb_slice_pkg::FUNC_BOOT ? e : 16'h0000};
  endfunction : exp_ipc
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Ask for the bus against given other lines, then end the tenure
  task automatic grant_run(input logic lk, input logic [7:0] oth, input logic g, input int n);
    lock_intent = lk;
    other_lines = oth;
    access_request = 1;
    for (int i = 0; i < 24 && bus_granted !== 1'b1; i++) step(1);
    chk(bus_granted, g);
    chk(exclusive_hold_signal, lk & g);
    if (n > 0) begin
      double_word_strobe = 1;
      step(n);
      double_word_strobe = 0;
    end
    chk(burst_limit_reached, g && n >= 128);
    access_request = 0;
    transfer_done = 1;
    step(1);
    transfer_done = 0;
    step(6);
    chk({bus_granted, master_request_line_n, exclusive_hold_signal}, 0);
    other_lines = 0;
  endtask : grant_run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(5);
    srst = 0;
    other_hold = 1;
    access_request = 1;
    step(8);
    chk(master_request_line_n, 0);
    other_hold = 0;
    grant_run(0, 8'h00, 1, 130);
    for (int k = 0; k < 8; k++) begin
      other_lines = k == 0 ? 8'hf8 : (k < 3 ? 8'(k) : 8'(rnd()));
      grant_run(k % 2 == 0, other_lines, other_lines[1:0] == 2'h0, k == 0 ? 127 : 0);
    end
    global_write = 1;
    for (int k = 0; k < 12; k++) begin
      global_target = 4'(rnd());
      global_function = 2'(k);
      step(1);
      chk({proc_interrupt, proc_reset, proc_boot}, exp_ipc(global_target, global_function));
    end
    global_write = 0;
    complete_run();
  end
endmodule : distributed_bus_arbiter_lock_tb_top
